//--- rtl/sps_pkg.sv
package sps_pkg;

    // Step index width: eight half-step positions per electrical period
    localparam int unsigned IDX_W = 3;

    // Sequence start position and reset values
    localparam logic [2:0] IDX_START = 3'h0;
    localparam logic [3:0] GATES_OFF = 4'h0;
    localparam logic MODE_RESET = 1'h0;

    // Mode select levels
    localparam logic MODE_FULL = 1'h0;
    localparam logic MODE_HALF = 1'h1;

    // Direction select levels
    localparam logic DIR_FWD = 1'h0;
    localparam logic DIR_REV = 1'h1;

    // Index strides per step
    localparam logic [2:0] STRIDE_HALF = 3'h1;
    localparam logic [2:0] STRIDE_FULL = 3'h2;

    // Gate patterns per half-step index, bit 0 is the first phase gate
    localparam logic [3:0] PAT_0 = 4'h1;
    localparam logic [3:0] PAT_1 = 4'h3;
    localparam logic [3:0] PAT_2 = 4'h2;
    localparam logic [3:0] PAT_3 = 4'h6;
    localparam logic [3:0] PAT_4 = 4'h4;
    localparam logic [3:0] PAT_5 = 4'hc;
    localparam logic [3:0] PAT_6 = 4'h8;
    localparam logic [3:0] PAT_7 = 4'h9;

    // Host timing: least reset hold and least step pulse width
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned RESET_HOLD_US = 20;
    localparam int unsigned STEP_PULSE_US = 20;
    localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_US * (CLK_HZ / 1_000_000));
    localparam int unsigned STEP_PULSE_CYC = (STEP_PULSE_US * (CLK_HZ / 1_000_000));

    // Edge detector state
    typedef struct packed {
        logic prev;
    } sps_edge_state_type;

    // Sequencer state
    typedef struct packed {
        logic [2:0] idx;
        logic mode;
        logic [3:0] gates;
    } sps_seq_state_type;

endpackage

//--- rtl/sps_edge_detect.sv
module sps_edge_detect (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic level_i,
    output logic rise_o
);

    sps_pkg::sps_edge_state_type state_ff;
    sps_pkg::sps_edge_state_type nxt_state;

    // Remember last level
    always_comb begin
        nxt_state = state_ff;
        nxt_state.prev = level_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Pulse on low-to-high only; falls and steady levels give nothing
    assign rise_o = level_i & ~state_ff.prev;

endmodule

//--- rtl/sps_sequencer.sv
// Operation
// - Phase state advances only on a rising step clock edge.
// - Mode select low gives 2-phase, high gives 1-2 phase stepping.
// - Direction select low steps forward, high steps in reverse order.
// - Device reset low holds sequencing in reset, all four gates off.
// - Reset acts on the low level, not on an edge.
// - After reset release the sequence starts with the first gate on.
// - In 1-2 phase mode some steps leave one winding undriven.
// - Mode select is sampled at the rising step clock edge.
module sps_sequencer (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic step_clock_i,
    input wire logic mode_select_i,
    input wire logic direction_select_i,
    input wire logic active_low_reset_n_i,
    output logic first_phase_gate_o,
    output logic second_phase_gate_o,
    output logic third_phase_gate_o,
    output logic fourth_phase_gate_o
);

    sps_pkg::sps_seq_state_type state_ff;
    sps_pkg::sps_seq_state_type nxt_state;
    logic step_rise;

    // Gate pattern of a half-step index
    function automatic logic [3:0] gate_pattern(input logic [2:0] idx);
        logic [3:0] pat;
        pat = sps_pkg::GATES_OFF;
        unique case (idx)
            3'h0: pat = sps_pkg::PAT_0;
            3'h1: pat = sps_pkg::PAT_1;
            3'h2: pat = sps_pkg::PAT_2;
            3'h3: pat = sps_pkg::PAT_3;
            3'h4: pat = sps_pkg::PAT_4;
            3'h5: pat = sps_pkg::PAT_5;
            3'h6: pat = sps_pkg::PAT_6;
            3'h7: pat = sps_pkg::PAT_7;
        endcase
        return pat;
    endfunction

    // Index shown in a mode: 2-phase always sits on a two-gate position
    function automatic logic [2:0] shown_index(input logic [2:0] idx, input logic mode);
        logic [2:0] res;
        res = (mode == sps_pkg::MODE_FULL) ? (idx | 3'h1) : idx;
        return res;
    endfunction

    // Step clock edge detector
    sps_edge_detect u_edge (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .level_i(step_clock_i),
        .rise_o(step_rise)
    );

    // Next state: reset, step, or hold
    always_comb begin
        logic [2:0] base;
        logic [2:0] stride;
        nxt_state = state_ff;
        base = sps_pkg::IDX_START;
        stride = sps_pkg::STRIDE_HALF;
        if (!active_low_reset_n_i) begin
            nxt_state.idx = sps_pkg::IDX_START;
            nxt_state.mode = sps_pkg::MODE_RESET;
            nxt_state.gates = sps_pkg::GATES_OFF;
        end else begin
            if (step_rise) begin
                nxt_state.mode = mode_select_i;
                base = shown_index(state_ff.idx, mode_select_i);
                stride = (mode_select_i == sps_pkg::MODE_HALF) ? sps_pkg::STRIDE_HALF
                                                               : sps_pkg::STRIDE_FULL;
                if (direction_select_i == sps_pkg::DIR_FWD) begin
                    nxt_state.idx = base + stride;
                end else begin
                    nxt_state.idx = base - stride;
                end
            end
            // Start index 0 lights the first gate in either mode
            nxt_state.gates = gate_pattern(shown_index(nxt_state.idx, nxt_state.mode));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_ff.idx <= sps_pkg::IDX_START;
            state_ff.mode <= sps_pkg::MODE_RESET;
            state_ff.gates <= sps_pkg::GATES_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Gate outputs straight from the state register
    assign first_phase_gate_o = state_ff.gates[0];
    assign second_phase_gate_o = state_ff.gates[1];
    assign third_phase_gate_o = state_ff.gates[2];
    assign fourth_phase_gate_o = state_ff.gates[3];

    // No step edge, no index change
    property p_no_edge_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (active_low_reset_n_i && !step_rise) |=> $stable(state_ff.idx);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold) else $error("index moved without step edge");

    // Mode low gives two gates on after the step
    property p_full_two_gates;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (active_low_reset_n_i && step_rise && !mode_select_i) ##1 active_low_reset_n_i
            |-> ##1 ($countones(state_ff.gates) == 2);
    endproperty
    a_full_two_gates: assert property (p_full_two_gates) else $error("2-phase step lacks two gates");

    // Forward half step adds one, reverse subtracts one
    property p_half_direction;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (active_low_reset_n_i && step_rise && mode_select_i)
            |=> (state_ff.idx == ($past(direction_select_i) ? $past(state_ff.idx) - 3'h1
                                                            : $past(state_ff.idx) + 3'h1));
    endproperty
    a_half_direction: assert property (p_half_direction) else $error("half step went wrong way");

    // Device reset low forces gates off next cycle
    property p_reset_off;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !active_low_reset_n_i |=> (state_ff.gates == 4'h0 && state_ff.idx == 3'h0);
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("gates not off in device reset");

    // A held low level keeps gates off, ignoring step edges
    property p_reset_level;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!active_low_reset_n_i)[*3] |-> (state_ff.gates == 4'h0) && $stable(state_ff.mode);
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("gates on while reset held low");

    // After release the first gate is on
    property p_release_first;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($rose(active_low_reset_n_i) && !step_rise) |=> first_phase_gate_o;
    endproperty
    a_release_first: assert property (p_release_first) else $error("first gate not on after release");

    // Half mode, even index: exactly one gate on
    property p_half_single;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($past(active_low_reset_n_i) && active_low_reset_n_i && state_ff.mode && !state_ff.idx[0])
            |-> ($countones(state_ff.gates) == 1);
    endproperty
    a_half_single: assert property (p_half_single) else $error("half mode single-gate step wrong");

    // Mode captured only at step edges
    property p_mode_sample;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        active_low_reset_n_i |=> (state_ff.mode == ($past(step_rise) ? $past(mode_select_i)
                                                                      : $past(state_ff.mode)));
    endproperty
    a_mode_sample: assert property (p_mode_sample) else $error("mode not sampled at step edge");

    // 2-phase shows two adjacent gates on, at any index
    property p_full_states;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $past(active_low_reset_n_i) && active_low_reset_n_i && !state_ff.mode)
            |-> ($countones(state_ff.gates) == 2) && first_phase_gate_o != third_phase_gate_o;
    endproperty
    a_full_states: assert property (p_full_states) else $error("2-phase state not adjacent pair");

    // Every accepted step edge moves the index
    property p_step_moves;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (active_low_reset_n_i && step_rise) |=> !$stable(state_ff.idx);
    endproperty
    a_step_moves: assert property (p_step_moves) else $error("step edge left index in place");

    // A falling step clock leaves the index alone
    property p_fall_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (active_low_reset_n_i && $fell(step_clock_i)) |=> $stable(state_ff.idx);
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("index moved on falling step clock");

    // Without a step, level changes on the selects leave the gates as they are
    property p_gates_hold;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $past(active_low_reset_n_i) && active_low_reset_n_i && !step_rise)
            |=> $stable(state_ff.gates);
    endproperty
    a_gates_hold: assert property (p_gates_hold) else $error("gates moved without step edge");

    // Forward 2-phase step adds two to the odd position, reverse subtracts two
    property p_full_direction;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (active_low_reset_n_i && step_rise && !mode_select_i)
            |=> (state_ff.idx == ($past(direction_select_i) ? ($past(state_ff.idx) | 3'h1) - 3'h2
                                                            : ($past(state_ff.idx) | 3'h1) + 3'h2));
    endproperty
    a_full_direction: assert property (p_full_direction) else $error("full step went wrong way");

    // Half mode, odd index: two adjacent gates on
    property p_half_pairs;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $past(active_low_reset_n_i) && active_low_reset_n_i && state_ff.mode && state_ff.idx[0])
            |-> ($countones(state_ff.gates) == 2);
    endproperty
    a_half_pairs: assert property (p_half_pairs) else $error("half mode two-gate step wrong");

    // Device reset returns the mode to 2-phase for a clean restart
    property p_reset_mode;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !active_low_reset_n_i |=> (state_ff.mode == sps_pkg::MODE_FULL);
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode not 2-phase after device reset");

    // Release shows the first gate with its neighbour, nothing else
    property p_release_pair;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ($rose(active_low_reset_n_i) && !step_rise)
            |=> (first_phase_gate_o && second_phase_gate_o && !third_phase_gate_o && !fourth_phase_gate_o);
    endproperty
    a_release_pair: assert property (p_release_pair) else $error("wrong gates after release");

    // Chip reset also cuts all gates
    property p_chip_reset_off;
        @(posedge clk_sys_i)
        !reset_n_i |=> (state_ff.gates == sps_pkg::GATES_OFF);
    endproperty
    a_chip_reset_off: assert property (p_chip_reset_off) else $error("gates on during chip reset");

endmodule

//--- verif/sps_host_model.sv
// Host controller side: power-up reset hold and step pulses on request
module sps_host_model #(
    parameter int unsigned PULSE_CYC = sps_pkg::STEP_PULSE_CYC,
    parameter int unsigned RESET_CYC = sps_pkg::RESET_HOLD_CYC
) (
    input wire logic clk_sys_i,
    input wire logic step_req_i,
    input wire logic hold_reset_i,
    output logic step_clock_o,
    output logic active_low_reset_n_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned rst_cnt = RESET_CYC;
    int unsigned cnt = 0;
    initial begin
        step_clock_o = 1'b0;
        active_low_reset_n_o = 1'b0;
    end
    assign busy_o = (cnt != 0);
    // Device reset held low after power-up, then follows the bench
    always @(negedge clk_sys_i) begin
        if (rst_cnt != 0) begin
            rst_cnt <= rst_cnt - 1;
        end
        active_low_reset_n_o <= (rst_cnt == 0) && !hold_reset_i;
    end
    // One step: high, then low, each at least the pulse width
    always @(negedge clk_sys_i) begin
        if (cnt != 0) begin
            cnt <= cnt - 1;
            step_clock_o <= (cnt - 1 >= PULSE_CYC);
        end else if (step_req_i) begin
            cnt <= 2 * PULSE_CYC;
            step_clock_o <= 1'b1;
        end
    end
endmodule

//--- verif/stepper_phase_sequencer_bench.sv
// Self-checking bench for the phase sequencer
module stepper_phase_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic mode_sel = 1'b0;
    logic dir_sel = 1'b0;
    logic step_req = 1'b0;
    logic hold_rst = 1'b0;
    logic step_clk, arst_n, busy;
    logic [3:0] gates;
    logic [2:0] e_idx = 3'h0;
    logic e_mode = 1'b0;
    int unsigned error_cnt = 0;
    int unsigned n_compared = 0;
    // Clock, 8 ns period
    always #4 clk_sys = ~clk_sys;
    sps_host_model #(.PULSE_CYC(4)) i_host (.clk_sys_i(clk_sys), .step_req_i(step_req),
        .hold_reset_i(hold_rst), .step_clock_o(step_clk), .active_low_reset_n_o(arst_n), .busy_o(busy));
    sps_sequencer i_dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .step_clock_i(step_clk),
        .mode_select_i(mode_sel), .direction_select_i(dir_sel), .active_low_reset_n_i(arst_n),
        .first_phase_gate_o(gates[0]), .second_phase_gate_o(gates[1]),
        .third_phase_gate_o(gates[2]), .fourth_phase_gate_o(gates[3]));
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared != 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Gate pattern of a half-step index: one gate, or it and the next
    function automatic logic [3:0] pat(input logic [2:0] i);
        logic [3:0] p;
        p = 4'h1 << i[2:1];
        if (i[0]) p = p | (4'h1 << (i[2:1] + 2'h1));
        return p;
    endfunction
    function automatic logic [3:0] exp_gates();
        return pat(e_mode ? e_idx : (e_idx | 3'h1));
    endfunction
    // One host step; live tells whether the device is out of reset
    task automatic do_step(input logic m, input logic d, input bit live);
        int k;
        @(negedge clk_sys);
        mode_sel <= m;
        dir_sel <= d;
        step_req <= 1'b1;
        @(negedge clk_sys);
        step_req <= 1'b0;
        // Host took the request at the previous edge; busy already shows at this one
        @(negedge clk_sys);
        for (k = 0; k < 100 && busy; k++) @(negedge clk_sys);
        if (busy) begin
            error_cnt++;
            give_verdict();
        end
        if (live) begin
            e_mode = m;
            if (m) e_idx = d ? e_idx - 3'h1 : e_idx + 3'h1;
            else e_idx = (e_idx | 3'h1) + (d ? 3'h6 : 3'h2);
        end
        check("gates", gates, live ? exp_gates() : 4'h0);
    endtask
    task automatic sc_power_up();
        int k;
        // Host still holds device reset low here
        repeat (4) @(negedge clk_sys);
        check("gates in reset", gates, 4'h0);
        for (k = 0; k < 3000 && !arst_n; k++) @(negedge clk_sys);
        if (!arst_n) begin
            error_cnt++;
            give_verdict();
        end
        @(negedge clk_sys);
        check("gates after reset", gates, 4'h3);
    endtask
    task automatic sc_walk(input logic m, input logic d, input int n);
        for (int k = 0; k < n; k++) do_step(m, d, 1'b1);
    endtask
    // Mode changed while idle must wait for the next step edge
    task automatic sc_mode_idle();
        @(negedge clk_sys);
        mode_sel <= 1'b0;
        repeat (10) @(negedge clk_sys);
        check("gates idle mode", gates, pat(e_idx));
        do_step(1'b0, 1'b0, 1'b1);
    endtask
    // Device reset mid-run; steps while low are ignored
    task automatic sc_dev_reset();
        @(negedge clk_sys);
        hold_rst <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check("gates held", gates, 4'h0);
        do_step(1'b1, 1'b0, 1'b0);
        @(negedge clk_sys);
        hold_rst <= 1'b0;
        repeat (3) @(negedge clk_sys);
        e_idx = 3'h0;
        e_mode = 1'b0;
        check("gates restart", gates, 4'h3);
        do_step(1'b0, 1'b0, 1'b1);
    endtask
    initial begin
        repeat (2) @(negedge clk_sys);
        reset_n <= 1'b1;
        sc_power_up();
        sc_walk(1'b0, 1'b0, 4);
        sc_walk(1'b0, 1'b1, 4);
        sc_walk(1'b1, 1'b0, 8);
        sc_walk(1'b1, 1'b1, 3);
        sc_mode_idle();
        sc_dev_reset();
        give_verdict();
    end
endmodule
